// file: hdl/standby_cfg.svh
// Purpose : constants of the standby and power saving controller
// Assumes : 32-bit classic wishbone, word aligned registers
// Notes   : offsets are byte addresses
`ifndef STANDBY_CFG_SVH
`define STANDBY_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define SB_CTRL_OFS      8'h00
`define SB_AUTO_OFS      8'h04
`define SB_STATIC_OFS    8'h08
`define SB_BANK_OFS      8'h0C
`define SB_CLKEN_OFS     8'h10
`define SB_GUARD_OFS     8'h14
`define SB_STAT_OFS      8'h18

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SB_CTRL_ENTER    0
`define SB_CTRL_EXIT     1
`define SB_AUTO_REF      0
`define SB_AUTO_MON      1
`define SB_AUTO_OSC      2
`define SB_AUTO_PLL      3
`define SB_AUTO_RCLK     4
`define SB_STATIC_OSC    0
`define SB_STATIC_PLL    1

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define SB_AUTO_RST      32'h0000_0000
`define SB_BANK_RST      32'h0000_0000
`define SB_CLKEN_RST     32'hFFFF_FFFF
`define SB_GUARD_RST     32'h0000_0000
`define SB_STEP_NS       100
`define SB_STEP_CYC      ((`SB_STEP_NS + 19) / 20)

`endif

// file: hdl/standby_pkg.sv
// Purpose : types of the standby and power saving controller
// Assumes : nothing
// Notes   : sequencer states only
package standby_pkg;
  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_PLL_LOW = 3'b001,
    ST_PWR_DN  = 3'b010,
    ST_STANDBY = 3'b011,
    ST_REF_UP  = 3'b100,
    ST_DEP_UP  = 3'b101
  } seq_state_t;
endpackage

// file: hdl/standby_power_saving_controller.sv
// Purpose : standby entry/exit sequencer with power gating outputs
// Assumes : standby and port command inputs come from outside, synchronised here
// Notes   : analog enables are active high; one step delay between phases
`timescale 1ns/100ps
`include "standby_cfg.svh"

module standby_power_saving_controller #(
  parameter int NPLL  = 2,
  parameter int NBANK = 3,
  parameter int NCLK  = 8,
  parameter int NBUF  = 16
) (
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // standby requests
  input  wire logic              standby_pin_i,
  input  wire logic              port_cmd_i,
  // monitors and pll feedback
  input  wire logic              mon_trip_i,
  input  wire logic              coarse_trip_i,
  input  wire logic [NPLL-1:0]   pll_clk_low_i,
  // power controls
  output logic                   ref_en_o,
  output logic                   mon_en_o,
  output logic                   coarse_mon_en_o,
  output logic                   osc_en_o,
  output logic [NPLL-1:0]        pll_clk_stop_o,
  output logic [NPLL-1:0]        pll_pwr_en_o,
  output logic [NBANK-1:0]       diff_en_o,
  output logic [NCLK-1:0]        clk_net_en_o,
  output logic [NBUF-1:0]        ibuf_en_o,
  output logic                   routed_clk_en_o,
  output logic                   core_pwr_en_o,
  output logic                   reconfig_o,
  output logic                   standby_o
);

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  logic [3+NPLL:0] meta_r;
  logic [3+NPLL:0] sync_r;
  logic [3+NPLL:0] sync_nxt;
  logic            pin_d_r;
  logic            cmd_d_r;

  // two stages; first stage read only by second
  always_comb begin
    sync_nxt = meta_r;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r  <= '0;
      sync_r  <= '0;
      pin_d_r <= 1'b0;
      cmd_d_r <= 1'b0;
    end else if (ce_i) begin
      meta_r  <= {pll_clk_low_i, coarse_trip_i, mon_trip_i, port_cmd_i, standby_pin_i};
      sync_r  <= sync_nxt;
      pin_d_r <= sync_r[0];
      cmd_d_r <= sync_r[1];
    end
  end

  logic            pin_tgl;
  logic            cmd_edge;
  logic            mon_trip_s;
  logic            coarse_s;
  logic [NPLL-1:0] pll_low_s;
  assign pin_tgl    = sync_r[0] ^ pin_d_r;
  assign cmd_edge   = sync_r[1] & ~cmd_d_r;
  assign mon_trip_s = sync_r[2];
  assign coarse_s   = sync_r[3];
  assign pll_low_s  = sync_r[3+NPLL:4];

  // --------------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------------
  logic [31:0] auto_r, auto_nxt;
  logic [31:0] stat_cfg_r, stat_cfg_nxt;
  logic [31:0] bank_r, bank_nxt;
  logic [31:0] clken_r, clken_nxt;
  logic [31:0] guard_r, guard_nxt;
  logic        ack_nxt;
  logic [31:0] dat_nxt;
  logic        sw_enter;
  logic        sw_exit;
  logic        wr;

  // byte lane merge, used for every writable register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction

  assign wr       = cyc_i & stb_i & we_i & ~ack_o;
  assign sw_enter = wr && adr_i == `SB_CTRL_OFS && sel_i[0] && dat_i[`SB_CTRL_ENTER];
  assign sw_exit  = wr && adr_i == `SB_CTRL_OFS && sel_i[0] && dat_i[`SB_CTRL_EXIT];

  standby_pkg::seq_state_t st_r, st_nxt;
  logic [2:0]              mon_live;

  // next register values and read mux; unmapped reads give zero, still acked
  always_comb begin
    auto_nxt     = auto_r;
    stat_cfg_nxt = stat_cfg_r;
    bank_nxt     = bank_r;
    clken_nxt    = clken_r;
    guard_nxt    = guard_r;
    ack_nxt      = cyc_i & stb_i & ~ack_o;
    dat_nxt      = 32'h0000_0000;
    if (wr) begin
      case (adr_i)
        `SB_AUTO_OFS:   auto_nxt     = merge(auto_r, dat_i, sel_i);
        `SB_STATIC_OFS: stat_cfg_nxt = merge(stat_cfg_r, dat_i, sel_i);
        `SB_BANK_OFS:   bank_nxt     = merge(bank_r, dat_i, sel_i);
        `SB_CLKEN_OFS:  clken_nxt    = merge(clken_r, dat_i, sel_i);
        `SB_GUARD_OFS:  guard_nxt    = merge(guard_r, dat_i, sel_i);
        default: ;
      endcase
    end
    if (cyc_i & stb_i & ~we_i & ~ack_o) begin
      case (adr_i)
        `SB_AUTO_OFS:   dat_nxt = auto_r;
        `SB_STATIC_OFS: dat_nxt = stat_cfg_r;
        `SB_BANK_OFS:   dat_nxt = bank_r;
        `SB_CLKEN_OFS:  dat_nxt = clken_r;
        `SB_GUARD_OFS:  dat_nxt = guard_r;
        `SB_STAT_OFS:   dat_nxt = {26'h0, mon_live, st_r};
        default:        dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_r     <= `SB_AUTO_RST;
      stat_cfg_r <= 32'h0000_0000;
      bank_r     <= `SB_BANK_RST;
      clken_r    <= `SB_CLKEN_RST;
      guard_r    <= `SB_GUARD_RST;
      ack_o      <= 1'b0;
      dat_o      <= 32'h0000_0000;
    end else if (ce_i) begin
      auto_r     <= auto_nxt;
      stat_cfg_r <= stat_cfg_nxt;
      bank_r     <= bank_nxt;
      clken_r    <= clken_nxt;
      guard_r    <= guard_nxt;
      ack_o      <= ack_nxt;
      dat_o      <= dat_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // standby sequencer
  // --------------------------------------------------------------------------
  localparam int STEP = `SB_STEP_CYC;
  logic [7:0] tmr_r, tmr_nxt;
  logic       enter_req;
  logic       exit_req;
  logic       tmr_done;
  logic       ref_off, osc_off, pll_off, mon_off, rclk_off;

  // a toggle or a port command while in standby requests exit
  assign enter_req = pin_tgl | cmd_edge | sw_enter;
  assign exit_req  = pin_tgl | cmd_edge | sw_exit;
  assign tmr_done  = tmr_r == 8'(STEP - 1);
  assign ref_off   = auto_r[`SB_AUTO_REF];
  assign mon_off   = auto_r[`SB_AUTO_MON] | ref_off;
  assign osc_off   = auto_r[`SB_AUTO_OSC] | ref_off;
  assign pll_off   = auto_r[`SB_AUTO_PLL] | ref_off;
  assign rclk_off  = auto_r[`SB_AUTO_RCLK];

  // next state; pll power held until every output clock reads low
  always_comb begin
    st_nxt  = st_r;
    tmr_nxt = 8'h00;
    case (st_r)
      standby_pkg::ST_RUN:
        if (enter_req) st_nxt = standby_pkg::ST_PLL_LOW;
      standby_pkg::ST_PLL_LOW:
        if (!pll_off || &pll_low_s) st_nxt = standby_pkg::ST_PWR_DN;
      // step counter restarts at each phase end, back to back phases get a full step
      standby_pkg::ST_PWR_DN: begin
        tmr_nxt = tmr_done ? 8'h00 : tmr_r + 8'h01;
        if (tmr_done) st_nxt = standby_pkg::ST_STANDBY;
      end
      standby_pkg::ST_STANDBY:
        if (exit_req) st_nxt = standby_pkg::ST_REF_UP;
      standby_pkg::ST_REF_UP: begin
        tmr_nxt = tmr_done ? 8'h00 : tmr_r + 8'h01;
        if (tmr_done) st_nxt = standby_pkg::ST_DEP_UP;
      end
      standby_pkg::ST_DEP_UP: begin
        tmr_nxt = tmr_done ? 8'h00 : tmr_r + 8'h01;
        if (tmr_done) st_nxt = standby_pkg::ST_RUN;
      end
      default: st_nxt = standby_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r  <= standby_pkg::ST_RUN;
      tmr_r <= 8'h00;
    end else if (ce_i) begin
      st_r  <= st_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // power control outputs
  // --------------------------------------------------------------------------
  logic dn, ref_dn, dep_dn, stop_clk;
  logic                   ref_en_nxt, mon_en_nxt, osc_en_nxt, rclk_nxt, reconf_nxt;
  logic [NPLL-1:0]        stop_nxt, pwr_nxt;
  logic [NBANK-1:0]       diff_nxt;

  // reference returns in ref_up, dependents only after it in dep_up
  assign dn       = st_r == standby_pkg::ST_PWR_DN || st_r == standby_pkg::ST_STANDBY;
  assign ref_dn   = dn & ref_off;
  assign dep_dn   = dn | st_r == standby_pkg::ST_REF_UP;
  assign stop_clk = st_r != standby_pkg::ST_RUN && st_r != standby_pkg::ST_DEP_UP;
  assign mon_live = {coarse_s, ~(mon_off & dep_dn), ~ref_dn};

  always_comb begin
    ref_en_nxt = ~ref_dn;
    mon_en_nxt = ~(dep_dn & mon_off);
    osc_en_nxt = ~stat_cfg_r[`SB_STATIC_OSC] & ~(dep_dn & osc_off);
    rclk_nxt   = ~(dep_dn & rclk_off);
    // full reconfiguration when the live monitor or coarse detector trips
    reconf_nxt = (mon_en_o & mon_trip_s) | coarse_s;
  end

  generate
    for (genvar p = 0; p < NPLL; p++) begin : g_pll
      logic stat_off;
      // static off: clocks stop at once, power waits until they read low
      assign stat_off = stat_cfg_r[`SB_STATIC_PLL + p];
      always_comb begin
        stop_nxt[p] = stat_off | (stop_clk & pll_off);
        pwr_nxt[p]  = ~(stat_off & pll_low_s[p]) & ~(dep_dn & pll_off);
      end
    end
    for (genvar b = 0; b < NBANK; b++) begin : g_bank
      always_comb begin
        diff_nxt[b] = ~bank_r[b] & ~(dep_dn & ref_off);
      end
    end
  endgenerate

  // outputs registered; core power never removed in standby
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_en_o        <= 1'b1;
      mon_en_o        <= 1'b1;
      coarse_mon_en_o <= 1'b1;
      osc_en_o        <= 1'b1;
      pll_clk_stop_o  <= '0;
      pll_pwr_en_o    <= '1;
      diff_en_o       <= '1;
      clk_net_en_o    <= '1;
      ibuf_en_o       <= '1;
      routed_clk_en_o <= 1'b1;
      core_pwr_en_o   <= 1'b1;
      reconfig_o      <= 1'b0;
      standby_o       <= 1'b0;
    end else if (ce_i) begin
      ref_en_o        <= ref_en_nxt;
      mon_en_o        <= mon_en_nxt;
      coarse_mon_en_o <= 1'b1;
      osc_en_o        <= osc_en_nxt;
      pll_clk_stop_o  <= stop_nxt;
      pll_pwr_en_o    <= pwr_nxt;
      diff_en_o       <= diff_nxt;
      clk_net_en_o    <= clken_r[NCLK-1:0];
      ibuf_en_o       <= ~guard_r[NBUF-1:0];
      routed_clk_en_o <= rclk_nxt;
      core_pwr_en_o   <= 1'b1;
      reconfig_o      <= reconf_nxt;
      standby_o       <= st_r == standby_pkg::ST_STANDBY;
    end
  end

endmodule

// file: tb/pll_far_end.sv
// Purpose: far side pll outputs answering clock stop requests
// Assumes: one clock, stop requests are registered levels
// Notes  : pll 0 answers promptly, the last pll slowly
`timescale 1ns/100ps
module pll_far_end #(
  parameter int NPLL = 2,
  parameter int DLY  = 4
) (
  input  wire logic            clk_i,
  input  wire logic [NPLL-1:0] stop_i,
  output logic      [NPLL-1:0] low_o
);
  logic [NPLL-1:0] pipe_r [DLY];
  // outputs settle low only some cycles after the stop, never before
  always_ff @(posedge clk_i) begin
    pipe_r[0] <= stop_i;
    for (int k = 1; k < DLY; k++) pipe_r[k] <= pipe_r[k-1];
  end
  // a released stop restarts the clocks at once
  always_comb begin
    for (int p = 0; p < NPLL; p++) low_o[p] = pipe_r[(p == 0) ? 0 : DLY-1][p] & stop_i[p];
  end
endmodule

// file: tb/standby_props.sv
// Purpose: port checks of the standby controller
// Assumes: one clock, synchronous reset active high
// Notes  : all enables active high
`timescale 1ns/100ps
module standby_props #(
  parameter int NPLL  = 2,
  parameter int NBANK = 3
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             ack_o,
  input wire logic             mon_trip_i,
  input wire logic             coarse_trip_i,
  input wire logic [NPLL-1:0]  pll_clk_low_i,
  input wire logic             ref_en_o,
  input wire logic             mon_en_o,
  input wire logic             coarse_mon_en_o,
  input wire logic             osc_en_o,
  input wire logic [NPLL-1:0]  pll_pwr_en_o,
  input wire logic [NBANK-1:0] diff_en_o,
  input wire logic             core_pwr_en_o,
  input wire logic             reconfig_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answer comes one cycle after a request and lasts one cycle
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  // dependents may never run without the reference
  AST_REF_DEPS: assert property (!ref_en_o |-> !mon_en_o && !osc_en_o && pll_pwr_en_o == '0
    && diff_en_o == '0) else $error("dependent on while reference off");
  AST_ALWAYS_ON: assert property (core_pwr_en_o && coarse_mon_en_o)
    else $error("core power or coarse detect dropped");
  // the slow pll is the one that exposes an early power cut
  AST_PLL_LOW: assert property ($fell(pll_pwr_en_o[NPLL-1]) |-> $past(pll_clk_low_i[NPLL-1]))
    else $error("pll powered off with clocks running");
  AST_REF_FIRST: assert property ($rose(osc_en_o) |-> $past(ref_en_o, 3))
    else $error("oscillator back before reference");
  AST_MON_TRIP: assert property ((mon_en_o && mon_trip_i) [*5] |-> reconfig_o)
    else $error("monitor trip without reconfiguration");
  AST_COARSE_TRIP: assert property (coarse_trip_i [*5] |-> reconfig_o)
    else $error("coarse trip without reconfiguration");
endmodule

bind standby_power_saving_controller standby_props #(.NPLL(NPLL), .NBANK(NBANK)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .mon_trip_i(mon_trip_i), .coarse_trip_i(coarse_trip_i), .pll_clk_low_i(pll_clk_low_i),
  .ref_en_o(ref_en_o), .mon_en_o(mon_en_o), .coarse_mon_en_o(coarse_mon_en_o),
  .osc_en_o(osc_en_o), .pll_pwr_en_o(pll_pwr_en_o), .diff_en_o(diff_en_o),
  .core_pwr_en_o(core_pwr_en_o), .reconfig_o(reconfig_o));

// file: tb/standby_power_saving_controller_test.sv
// Purpose: directed bench of the standby controller
// Assumes: default parameters, 50 MHz clock
// Notes  : entry by pin, port command and register in turn
`timescale 1ns/100ps
`include "standby_cfg.svh"
module standby_power_saving_controller_test;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic        ack_o, standby_pin_i = 1'b0, port_cmd_i = 1'b0;
  logic        mon_trip_i = 1'b0, coarse_trip_i = 1'b0;
  logic [1:0]  pll_clk_low_i, pll_clk_stop_o, pll_pwr_en_o;
  logic [2:0]  diff_en_o;
  logic [7:0]  clk_net_en_o;
  logic [15:0] ibuf_en_o;
  logic        ref_en_o, mon_en_o, coarse_mon_en_o, osc_en_o, routed_clk_en_o;
  logic        core_pwr_en_o, reconfig_o, standby_o;
  logic [4:0]  a;
  int          miscompares = 0, tests_run = 0;

  always #10 clk_i = ~clk_i;

  standby_power_saving_controller dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .standby_pin_i(standby_pin_i), .port_cmd_i(port_cmd_i), .mon_trip_i(mon_trip_i),
    .coarse_trip_i(coarse_trip_i), .pll_clk_low_i(pll_clk_low_i), .ref_en_o(ref_en_o),
    .mon_en_o(mon_en_o), .coarse_mon_en_o(coarse_mon_en_o), .osc_en_o(osc_en_o),
    .pll_clk_stop_o(pll_clk_stop_o), .pll_pwr_en_o(pll_pwr_en_o), .diff_en_o(diff_en_o),
    .clk_net_en_o(clk_net_en_o), .ibuf_en_o(ibuf_en_o), .routed_clk_en_o(routed_clk_en_o),
    .core_pwr_en_o(core_pwr_en_o), .reconfig_o(reconfig_o), .standby_o(standby_o));

  pll_far_end #(.NPLL(2), .DLY(4)) far (
    .clk_i(clk_i), .stop_i(pll_clk_stop_o), .low_o(pll_clk_low_i));

  // -------------------------------------------------------------------------
  // access and compare tasks
  // -------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= ad;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
    if (n >= 20) miscompares++;
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wait_sb(input logic v);
    int n = 0;
    while (standby_o !== v && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk(standby_o, v);
  endtask

  // pin toggle, port command pulse or control register, both ways
  task automatic kick(input int m, input logic enter);
    case (m)
      0: begin @(posedge clk_i); standby_pin_i <= ~standby_pin_i; end
      1: begin @(posedge clk_i); port_cmd_i <= 1'b1; repeat (4) @(posedge clk_i); port_cmd_i <= 1'b0; end
      default: wb(1'b1, `SB_CTRL_OFS, enter ? 32'h1 : 32'h2);
    endcase
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `SB_AUTO_OFS, 32'h0);
    chk(q, `SB_AUTO_RST);
    wb(1'b0, `SB_CLKEN_OFS, 32'h0);
    chk(q, `SB_CLKEN_RST);
    wb(1'b0, `SB_GUARD_OFS, 32'h0);
    chk(q, `SB_GUARD_RST);
    wb(1'b1, `SB_BANK_OFS, 32'h5);
    wb(1'b1, `SB_CLKEN_OFS, 32'h0F);
    wb(1'b1, `SB_GUARD_OFS, 32'hF0);
    wb(1'b1, `SB_STATIC_OFS, 32'h1);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk({diff_en_o, clk_net_en_o, ibuf_en_o, osc_en_o}, {3'h2, 8'h0F, 16'hFF0F, 1'b0});
    // static pll shutdown: clocks stop first, power follows once they read low
    wb(1'b1, `SB_STATIC_OFS, 32'h6);
    @(posedge clk_i);
    chk({pll_clk_stop_o, pll_pwr_en_o}, 4'hF);
    repeat (10) @(posedge clk_i);
    chk({pll_clk_stop_o, pll_pwr_en_o}, 4'hC);
    wb(1'b1, `SB_STATIC_OFS, 32'h0);
    // trips while running, precise then coarse
    for (int i = 0; i < 2; i++) begin
      mon_trip_i <= (i == 0);
      coarse_trip_i <= (i == 1);
      repeat (6) @(posedge clk_i);
      chk(reconfig_o, 1'b1);
      mon_trip_i <= 1'b0;
      coarse_trip_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(reconfig_o, 1'b0);
    end
    // standby round trips with different automatic selections
    for (int m = 0; m < 3; m++) begin
      a = (m == 0) ? 5'h1F : (m == 1) ? 5'h04 : 5'h0A;
      wb(1'b1, `SB_AUTO_OFS, {27'h0, a});
      kick(m, 1'b1);
      wait_sb(1'b1);
      @(posedge clk_i);
      chk({ref_en_o, mon_en_o, osc_en_o, pll_pwr_en_o, diff_en_o, routed_clk_en_o, core_pwr_en_o,
        coarse_mon_en_o}, {~a[0], ~(a[0] | a[1]), ~(a[0] | a[2]), {2{~(a[0] | a[3])}},
        a[0] ? 3'h0 : 3'h2, ~a[4], 2'b11});
      wb(1'b0, `SB_STAT_OFS, 32'h0);
      chk(q[5:0], {1'b0, ~(a[0] | a[1]), ~a[0], 3'h3});
      kick(m, 1'b0);
      wait_sb(1'b0);
      repeat (12) @(posedge clk_i);
      chk({ref_en_o, mon_en_o, osc_en_o, pll_pwr_en_o, diff_en_o, routed_clk_en_o, core_pwr_en_o,
        coarse_mon_en_o}, 11'h7D7);
    end
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    end_of_test;
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_of_test;
  end
endmodule
